// File: core/cgcr_toggle_div.sv
// square wave divider used for both chopper outputs
// assumes the half period count comes from logic on the same clock
`default_nettype none
module cgcr_toggle_div (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [31:0] i_half,
  output var  logic        o_wave
);
  cgcr_pkg::cgcr_div_type r_ff;
  cgcr_pkg::cgcr_div_type nxt_r;

  // zero half period parks the output high; >= keeps a shrinking count safe
  always_comb
  begin
    nxt_r = r_ff;
    if (i_half == 32'h0)
    begin
      nxt_r.cnt  = 32'h0;
      nxt_r.wave = 1'b1;
    end
    else if (r_ff.cnt >= i_half - 32'h1)
    begin
      nxt_r.cnt  = 32'h0;
      nxt_r.wave = ~r_ff.wave;
    end
    else
    begin
      nxt_r.cnt = r_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      r_ff <= cgcr_pkg::DIV_RST;
    else
      r_ff <= nxt_r;
  end

  assign o_wave = r_ff.wave;
endmodule : cgcr_toggle_div
`default_nettype wire

// File: core/cgcr_top.sv
// global command decoder and register set of the eight channel voice codec
// assumes a byte stream from host logic on I_MCLK; mode and sense pins are asynchronous
//
// Function
// - soft reset command pulses local reset; global registers and ram untouched
// - hard reset command reloads the reset-pin register state and pulses local reset; chopper dividers are not reset
// - clock select read by one code, written by code with top bit set
// - four-bit clock code maps to the listed master clock frequencies
// - clock select only in parallel mode; serial mode follows double-rate pin
// - one enable bit per channel for local and ram commands, default off
// - parallel mode slot offset delays slots zero to seven bit clocks
// - parallel mode clock-slope top bit selects single or double clock
// - parallel mode low slope bits choose transmit and receive clock edges
// - format bit selects compressed or linear samples in both modes
// - law bit selects a-law or mu-law in both modes
// - chopper a high at zero, else square wave of 1000/(2n) hz
// - chopper b high at 00, else 512 khz, 256 khz, 16.384 mhz
// - sense a status reads debounced per-channel levels, zero after reset
// - reserved bits are ignored on write and read as zero
// - no reset touches coefficient or tone ram contents
`default_nettype none
module cgcr_top #(
  parameter int unsigned P_CHOP_A_UNIT_CYC = cgcr_pkg::CHOP_A_UNIT_CYC,
  parameter int unsigned P_DEBOUNCE_CYC    = cgcr_pkg::DEBOUNCE_CYC,
  parameter int unsigned P_CHANNELS        = 8
) (
  input  wire logic                       I_MCLK,
  input  wire logic                       I_RST,
  input  wire logic                       I_PARALLEL_MODE,
  input  wire logic                       I_DOUBLE_RATE,
  input  wire logic                       I_BYTE_VALID,
  input  wire logic [7:0]                 I_BYTE,
  input  wire logic [P_CHANNELS-1:0]      I_SENSE_A,
  output var  logic                       O_RD_VALID,
  output var  logic [7:0]                 O_RD_DATA,
  output var  logic                       O_LOCAL_RESET,
  output var  logic [3:0]                 O_MCLK_CODE,
  output var  logic                       O_CODE_UNRESOLVED,
  output var  logic [P_CHANNELS-1:0]      O_CHAN_CMD_ENABLE,
  output var  cgcr_pkg::cgcr_pcm_cfg_type O_PCM_CFG,
  output var  logic                       O_CHOP_A,
  output var  logic                       O_CHOP_B
);
  cgcr_pkg::cgcr_top_type r_ff;
  cgcr_pkg::cgcr_top_type nxt_r;
  logic                   cmd_take;
  logic                   data_take;
  logic                   parallel;
  logic [31:0]            chop_a_half;
  logic [31:0]            chop_b_half;
  logic [3:0]             chop_a_code;
  logic [1:0]             chop_b_code;

  assign cmd_take  = I_BYTE_VALID && (r_ff.st == cgcr_pkg::ST_IDLE);
  assign data_take = I_BYTE_VALID && (r_ff.st == cgcr_pkg::ST_DATA);
  assign parallel  = r_ff.par_s2;

  // command parser, register file, pin synchronisers and sense debounce
  always_comb
  begin
    nxt_r           = r_ff;
    nxt_r.rd_valid  = 1'b0;
    nxt_r.local_rst = 1'b0;
    // two flops on every mode, rate and sense pin before use
    nxt_r.par_s1    = I_PARALLEL_MODE;
    nxt_r.par_s2    = r_ff.par_s1;
    nxt_r.dbl_s1    = I_DOUBLE_RATE;
    nxt_r.dbl_s2    = r_ff.dbl_s1;
    nxt_r.sen_s1    = 8'(I_SENSE_A);
    nxt_r.sen_s2    = r_ff.sen_s1;
    // whole vector must hold still; any change restarts the wait
    if (r_ff.sen_s2 != r_ff.sen_cand)
    begin
      nxt_r.sen_cand = r_ff.sen_s2;
      nxt_r.deb_cnt  = 32'h0;
    end
    else if (r_ff.deb_cnt < 32'(P_DEBOUNCE_CYC) - 32'h1)
    begin
      nxt_r.deb_cnt = r_ff.deb_cnt + 32'h1;
    end
    else
    begin
      nxt_r.sen_deb = r_ff.sen_cand;
    end

    // first byte of a transfer is the command
    if (cmd_take)
    begin
      nxt_r.cmd = I_BYTE;
      if (I_BYTE[cgcr_pkg::WRITE_BIT])
      begin
        nxt_r.st = cgcr_pkg::ST_DATA;
      end
      else
      begin
        nxt_r.rd_valid = 1'b1;
        unique case (I_BYTE[6:0])
          cgcr_pkg::REG_MASTER_CLOCK_SELECT:
            nxt_r.rd_data = {4'h0, r_ff.mclk};
          cgcr_pkg::REG_CHANNEL_COMMAND_ENABLE:
            nxt_r.rd_data = r_ff.chan_en;
          cgcr_pkg::REG_PCM_FORMAT_CONFIG:
            nxt_r.rd_data = r_ff.pcm;
          cgcr_pkg::REG_CHOPPER_CLOCK_CONFIG:
            nxt_r.rd_data = {2'h0, r_ff.chop};
          cgcr_pkg::REG_SENSE_A_DEBOUNCED_STATUS:
            nxt_r.rd_data = r_ff.sen_deb;
          default:
            nxt_r.rd_data = 8'h00;
        endcase
      end
    end

    // second byte carries the data of a write command
    if (data_take)
    begin
      nxt_r.st = cgcr_pkg::ST_IDLE;
      unique case (r_ff.cmd)
        cgcr_pkg::CMD_SOFT_RESET:
          nxt_r.local_rst = 1'b1;
        cgcr_pkg::CMD_NOP:
          nxt_r.local_rst = 1'b0; // trailing byte simply closes the command
        cgcr_pkg::CMD_HARD_RESET:
        begin
          // same state the pin leaves; synchronisers restart too
          nxt_r           = cgcr_pkg::TOP_RST;
          nxt_r.local_rst = 1'b1;
        end
        {1'b1, cgcr_pkg::REG_MASTER_CLOCK_SELECT}:
          if (parallel)
            nxt_r.mclk = I_BYTE[3:0];
        {1'b1, cgcr_pkg::REG_CHANNEL_COMMAND_ENABLE}:
          if (parallel)
            nxt_r.chan_en = I_BYTE;
        {1'b1, cgcr_pkg::REG_PCM_FORMAT_CONFIG}:
          nxt_r.pcm = I_BYTE;
        {1'b1, cgcr_pkg::REG_CHOPPER_CLOCK_CONFIG}:
          nxt_r.chop = I_BYTE[5:0];
        default:
          nxt_r.st = cgcr_pkg::ST_IDLE; // unknown writes swallow their byte
      endcase
    end
  end

  // ram is outside this block; neither reset path reaches it
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      r_ff <= cgcr_pkg::TOP_RST;
    else
      r_ff <= nxt_r;
  end

  // effective clock code: serial mode ignores the register
  always_comb
  begin
    if (parallel)
      O_MCLK_CODE = r_ff.mclk;
    else if (r_ff.dbl_s2)
      O_MCLK_CODE = cgcr_pkg::MCLK_DCL_DOUBLE;
    else
      O_MCLK_CODE = cgcr_pkg::MCLK_DCL_SINGLE;
  end

  // ambiguous 0110 and unlisted codes raise a flag rather than guess
  always_comb
  begin
    unique case (O_MCLK_CODE)
      cgcr_pkg::MCLK_8192, cgcr_pkg::MCLK_4096, cgcr_pkg::MCLK_2048,
      cgcr_pkg::MCLK_6144, cgcr_pkg::MCLK_3072, cgcr_pkg::MCLK_6176,
      cgcr_pkg::MCLK_3088:
        O_CODE_UNRESOLVED = (chop_a_code > cgcr_pkg::CHOP_A_MAX);
      default:
        O_CODE_UNRESOLVED = 1'b1;
    endcase
  end

  // pcm format; serial mode keeps offset and edges at their reset meaning
  always_comb
  begin
    O_PCM_CFG        = '0;
    O_PCM_CFG.linear = r_ff.pcm[cgcr_pkg::PCM_LINEAR_BIT];
    O_PCM_CFG.mulaw  = r_ff.pcm[cgcr_pkg::PCM_MULAW_BIT];
    if (parallel)
    begin
      O_PCM_CFG.slot_offset  = r_ff.pcm[cgcr_pkg::PCM_DO_LSB +: 3];
      O_PCM_CFG.double_clock = r_ff.pcm[cgcr_pkg::PCM_DOUBLE_BIT];
      O_PCM_CFG.tx_falling   = r_ff.pcm[cgcr_pkg::PCM_TX_BIT];
      O_PCM_CFG.rx_rising    = r_ff.pcm[cgcr_pkg::PCM_RX_BIT];
    end
  end

  // chopper half periods; product is wide, zero code parks output high
  assign chop_a_code = r_ff.chop[cgcr_pkg::CHOP_A_LSB +: 4];
  assign chop_b_code = r_ff.chop[cgcr_pkg::CHOP_B_LSB +: 2];
  assign chop_a_half = 32'(chop_a_code) * 32'(P_CHOP_A_UNIT_CYC);

  always_comb
  begin
    unique case (chop_b_code)
      2'h0:    chop_b_half = 32'h0;
      2'h1:    chop_b_half = 32'(cgcr_pkg::CHOP_B_F1_CYC);
      2'h2:    chop_b_half = 32'(cgcr_pkg::CHOP_B_F2_CYC);
      default: chop_b_half = 32'(cgcr_pkg::CHOP_B_F3_CYC);
    endcase
  end

  cgcr_toggle_div u_chop_a (
    .i_clk  (I_MCLK),
    .i_rst  (I_RST),
    .i_half (chop_a_half),
    .o_wave (O_CHOP_A)
  );

  cgcr_toggle_div u_chop_b (
    .i_clk  (I_MCLK),
    .i_rst  (I_RST),
    .i_half (chop_b_half),
    .o_wave (O_CHOP_B)
  );

  assign O_RD_VALID        = r_ff.rd_valid;
  assign O_RD_DATA         = r_ff.rd_data;
  assign O_LOCAL_RESET     = r_ff.local_rst;
  assign O_CHAN_CMD_ENABLE = P_CHANNELS'(r_ff.chan_en);

  // checks
  property p_soft_reset;
    @(posedge I_MCLK) disable iff (I_RST)
    data_take && r_ff.cmd == cgcr_pkg::CMD_SOFT_RESET
      |=> O_LOCAL_RESET && r_ff.mclk == $past(r_ff.mclk) && r_ff.pcm == $past(r_ff.pcm);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset misbehaved");

  property p_hard_reset;
    @(posedge I_MCLK) disable iff (I_RST)
    data_take && r_ff.cmd == cgcr_pkg::CMD_HARD_RESET
      |=> O_LOCAL_RESET && r_ff.mclk == cgcr_pkg::MCLK_RST && r_ff.chan_en == 8'h00
          && r_ff.chop == 6'h00 ##1 O_CHOP_B && !O_LOCAL_RESET;
  endproperty
  a_hard_reset: assert property (p_hard_reset) else $error("hard reset misbehaved");

  property p_mclk_write;
    @(posedge I_MCLK) disable iff (I_RST)
    data_take && parallel && r_ff.cmd == {1'b1, cgcr_pkg::REG_MASTER_CLOCK_SELECT}
      |=> r_ff.mclk == $past(I_BYTE[3:0]) ##1 O_MCLK_CODE == $past(I_BYTE[3:0], 2)
          || !parallel;
  endproperty
  a_mclk_write: assert property (p_mclk_write) else $error("clock select write lost");

  property p_mclk_read;
    @(posedge I_MCLK) disable iff (I_RST)
    cmd_take && I_BYTE == {1'b0, cgcr_pkg::REG_MASTER_CLOCK_SELECT}
      |=> O_RD_VALID && O_RD_DATA == {4'h0, $past(r_ff.mclk)}
          ##1 (!O_RD_VALID || $past(cmd_take && !I_BYTE[cgcr_pkg::WRITE_BIT]));
  endproperty
  a_mclk_read: assert property (p_mclk_read) else $error("clock select read wrong");

  property p_serial_clock;
    @(posedge I_MCLK) disable iff (I_RST)
    !parallel |-> O_MCLK_CODE == (r_ff.dbl_s2 ? cgcr_pkg::MCLK_DCL_DOUBLE
                                              : cgcr_pkg::MCLK_DCL_SINGLE);
  endproperty
  a_serial_clock: assert property (p_serial_clock) else $error("serial clock code wrong");

  property p_ambiguous;
    @(posedge I_MCLK) disable iff (I_RST)
    O_MCLK_CODE == cgcr_pkg::MCLK_1536_1544 |-> O_CODE_UNRESOLVED;
  endproperty
  a_ambiguous: assert property (p_ambiguous) else $error("ambiguous code not flagged");

  property p_chan_enable;
    @(posedge I_MCLK) disable iff (I_RST)
    data_take && parallel && r_ff.cmd == {1'b1, cgcr_pkg::REG_CHANNEL_COMMAND_ENABLE}
      |=> O_CHAN_CMD_ENABLE == P_CHANNELS'($past(I_BYTE));
  endproperty
  a_chan_enable: assert property (p_chan_enable) else $error("channel mask not taken");

  property p_pcm_fields;
    @(posedge I_MCLK) disable iff (I_RST)
    parallel |-> O_PCM_CFG.slot_offset == r_ff.pcm[2:0] && O_PCM_CFG.tx_falling == r_ff.pcm[4]
                 && O_PCM_CFG.double_clock == r_ff.pcm[5] && O_PCM_CFG.mulaw == r_ff.pcm[7];
  endproperty
  a_pcm_fields: assert property (p_pcm_fields) else $error("pcm format fields wrong");

  property p_chop_b_idle;
    @(posedge I_MCLK) disable iff (I_RST)
    chop_b_code == 2'h0 && $stable(chop_b_code) |=> O_CHOP_B;
  endproperty
  a_chop_b_idle: assert property (p_chop_b_idle) else $error("chopper b not parked");

  property p_chop_b_fast;
    @(posedge I_MCLK) disable iff (I_RST)
    chop_b_code == 2'h3 && $changed(O_CHOP_B) ##1 (chop_b_code == 2'h3) [*7]
      |-> $changed(O_CHOP_B);
  endproperty
  a_chop_b_fast: assert property (p_chop_b_fast) else $error("fast chopper period wrong");

  property p_chop_a_idle;
    @(posedge I_MCLK) disable iff (I_RST)
    chop_a_code == 4'h0 && $stable(chop_a_code) |=> O_CHOP_A;
  endproperty
  a_chop_a_idle: assert property (p_chop_a_idle) else $error("chopper a not parked");

  c_soft_reset: cover property (@(posedge I_MCLK) disable iff (I_RST) O_LOCAL_RESET);
  c_read_back:  cover property (@(posedge I_MCLK) disable iff (I_RST) O_RD_VALID ##1 O_RD_VALID);
  c_chop_b:     cover property (@(posedge I_MCLK) disable iff (I_RST) chop_b_code == 2'h3
                                ##0 $fell(O_CHOP_B));
endmodule : cgcr_top
`default_nettype wire

// File: pkg/cgcr_pkg.sv
// constants, field layouts, reset values and types of the global command block
// assumes a single 250 MHz core clock and a byte-wide command stream from the host
`default_nettype none
package cgcr_pkg;
  // core clock
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned CLK_PERIOD_NS = 4;

  // command byte layout: bit 7 set marks a write
  localparam int          WRITE_BIT     = 7;
  localparam logic [7:0]  CMD_NOP        = 8'ha0;
  localparam logic [7:0]  CMD_SOFT_RESET = 8'ha2;
  localparam logic [7:0]  CMD_HARD_RESET = 8'ha3;
  localparam logic [6:0]  REG_MASTER_CLOCK_SELECT      = 7'h24;
  localparam logic [6:0]  REG_CHANNEL_COMMAND_ENABLE   = 7'h25;
  localparam logic [6:0]  REG_PCM_FORMAT_CONFIG        = 7'h26;
  localparam logic [6:0]  REG_CHOPPER_CLOCK_CONFIG     = 7'h27;
  localparam logic [6:0]  REG_SENSE_A_DEBOUNCED_STATUS = 7'h28;

  // master clock frequency codes
  localparam logic [3:0]  MCLK_8192      = 4'h0;
  localparam logic [3:0]  MCLK_4096      = 4'h1;
  localparam logic [3:0]  MCLK_2048      = 4'h2;
  localparam logic [3:0]  MCLK_6144      = 4'h4;
  localparam logic [3:0]  MCLK_3072      = 4'h5;
  localparam logic [3:0]  MCLK_1536_1544 = 4'h6;
  localparam logic [3:0]  MCLK_6176      = 4'hc;
  localparam logic [3:0]  MCLK_3088      = 4'hd;
  localparam logic [3:0]  MCLK_RST       = MCLK_2048;
  localparam logic [3:0]  MCLK_DCL_SINGLE = MCLK_2048;
  localparam logic [3:0]  MCLK_DCL_DOUBLE = MCLK_4096;

  // reset values and field positions
  localparam logic [7:0]  CHAN_EN_RST    = 8'h00;
  localparam logic [7:0]  PCM_RST        = 8'h00;
  localparam logic [5:0]  CHOP_RST       = 6'h00;
  localparam int          PCM_DO_LSB     = 0;
  localparam int          PCM_RX_BIT     = 3;
  localparam int          PCM_TX_BIT     = 4;
  localparam int          PCM_DOUBLE_BIT = 5;
  localparam int          PCM_LINEAR_BIT = 6;
  localparam int          PCM_MULAW_BIT  = 7;
  localparam int          CHOP_A_LSB     = 0;
  localparam int          CHOP_B_LSB     = 4;
  localparam logic [3:0]  CHOP_A_MAX     = 4'hd;

  // chopper a half period is code times one millisecond
  localparam int unsigned CHOP_A_UNIT_NS  = 1_000_000;
  localparam int unsigned CHOP_A_UNIT_CYC = CHOP_A_UNIT_NS / CLK_PERIOD_NS;
  // chopper b half periods, rounded down
  localparam int unsigned CHOP_B_F1_HZ  = 512_000;
  localparam int unsigned CHOP_B_F2_HZ  = 256_000;
  localparam int unsigned CHOP_B_F3_HZ  = 16_384_000;
  localparam int unsigned CHOP_B_F1_CYC = CLK_HZ / (2 * CHOP_B_F1_HZ);
  localparam int unsigned CHOP_B_F2_CYC = CLK_HZ / (2 * CHOP_B_F2_HZ);
  localparam int unsigned CHOP_B_F3_CYC = CLK_HZ / (2 * CHOP_B_F3_HZ);
  // sense input must hold this long before it is taken
  localparam int unsigned DEBOUNCE_NS  = 8_000_000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_NS / CLK_PERIOD_NS;

  typedef enum logic {ST_IDLE, ST_DATA} cgcr_state_type;

  typedef struct packed {
    logic [2:0] slot_offset;
    logic       double_clock;
    logic       tx_falling;
    logic       rx_rising;
    logic       linear;
    logic       mulaw;
  } cgcr_pcm_cfg_type;

  typedef struct packed {
    cgcr_state_type st;
    logic [7:0]     cmd;
    logic [3:0]     mclk;
    logic [7:0]     chan_en;
    logic [7:0]     pcm;
    logic [5:0]     chop;
    logic           rd_valid;
    logic [7:0]     rd_data;
    logic           local_rst;
    logic           par_s1;
    logic           par_s2;
    logic           dbl_s1;
    logic           dbl_s2;
    logic [7:0]     sen_s1;
    logic [7:0]     sen_s2;
    logic [7:0]     sen_cand;
    logic [31:0]    deb_cnt;
    logic [7:0]     sen_deb;
  } cgcr_top_type;

  localparam cgcr_top_type TOP_RST = '{st: ST_IDLE, mclk: MCLK_RST, default: '0};

  typedef struct packed {
    logic [31:0] cnt;
    logic        wave;
  } cgcr_div_type;

  localparam cgcr_div_type DIV_RST = '{cnt: 32'h0, wave: 1'b1};
endpackage : cgcr_pkg
`default_nettype wire

// File: verif/cgcr_host_model.sv
// host side of the command byte stream: write, read and global commands
// assumes the device answers reads on the same clock within a few cycles
`default_nettype none
module cgcr_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  output var  logic       o_byte_valid,
  output var  logic [7:0] o_byte
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial
  begin
    o_byte_valid = 1'b0;
    o_byte       = 8'h00;
  end

  // command byte then one data byte; reserved bits are the caller's job
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(posedge i_clk);
    #1;
    o_byte_valid = 1'b1;
    o_byte       = cmd;
    @(posedge i_clk);
    #1;
    o_byte = data;
    @(posedge i_clk);
    #1;
    o_byte_valid = 1'b0;
    o_byte       = ~data; // released bus must not look like the last byte
  endtask : wr

  // reset and no-op commands always get the all-ones trailer
  task automatic global_cmd(input logic [7:0] cmd);
    wr(cmd, 8'hff);
  endtask : global_cmd

  // read command alone; answer awaited for a few cycles at most
  task automatic rd(input logic [6:0] addr, output logic [7:0] data, output bit ok);
    int k;
    @(posedge i_clk);
    #1;
    o_byte_valid = 1'b1;
    o_byte       = {1'b0, addr};
    @(posedge i_clk);
    #1;
    o_byte_valid = 1'b0;
    o_byte       = ~o_byte;
    ok   = 1'b0;
    data = 8'h00;
    for (k = 0; k < 4 && !ok; k++)
    begin
      if (i_rd_valid === 1'b1)
      begin
        ok   = 1'b1;
        data = i_rd_data;
      end
      else
      begin
        @(posedge i_clk);
        #1;
      end
    end
  endtask : rd
endmodule : cgcr_host_model
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the global command register block
// assumes short chopper unit and debounce counts set at the instance
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                       I_MCLK = 1'b0;
  logic                       I_RST = 1'b1;
  logic                       I_PARALLEL_MODE;
  logic                       I_DOUBLE_RATE;
  logic [7:0]                 I_SENSE_A;
  logic                       I_BYTE_VALID;
  logic [7:0]                 I_BYTE;
  logic                       O_RD_VALID;
  logic [7:0]                 O_RD_DATA;
  logic                       O_LOCAL_RESET;
  logic [3:0]                 O_MCLK_CODE;
  logic                       O_CODE_UNRESOLVED;
  logic [7:0]                 O_CHAN_CMD_ENABLE;
  cgcr_pkg::cgcr_pcm_cfg_type O_PCM_CFG;
  logic                       O_CHOP_A;
  logic                       O_CHOP_B;
  int                         n_mismatch = 0;
  int                         checked = 0;
  int                         cycles = 0;
  int                         pulses = 0;

  cgcr_top #(.P_CHOP_A_UNIT_CYC(10), .P_DEBOUNCE_CYC(8)) dut (
    .I_MCLK(I_MCLK), .I_RST(I_RST), .I_PARALLEL_MODE(I_PARALLEL_MODE),
    .I_DOUBLE_RATE(I_DOUBLE_RATE), .I_BYTE_VALID(I_BYTE_VALID), .I_BYTE(I_BYTE),
    .I_SENSE_A(I_SENSE_A), .O_RD_VALID(O_RD_VALID), .O_RD_DATA(O_RD_DATA),
    .O_LOCAL_RESET(O_LOCAL_RESET), .O_MCLK_CODE(O_MCLK_CODE),
    .O_CODE_UNRESOLVED(O_CODE_UNRESOLVED), .O_CHAN_CMD_ENABLE(O_CHAN_CMD_ENABLE),
    .O_PCM_CFG(O_PCM_CFG), .O_CHOP_A(O_CHOP_A), .O_CHOP_B(O_CHOP_B));

  cgcr_host_model host (.i_clk(I_MCLK), .i_rd_valid(O_RD_VALID), .i_rd_data(O_RD_DATA),
    .o_byte_valid(I_BYTE_VALID), .o_byte(I_BYTE));

  // 250 MHz core clock
  always #2 I_MCLK = ~I_MCLK;

  // cycle ceiling and local reset pulse count
  always @(posedge I_MCLK)
  begin
    cycles++;
    if (O_LOCAL_RESET === 1'b1)
      pulses++;
    if (cycles == 30000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // read must answer within three cycles with the given byte
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit         ok;
    host.rd(a, d, ok);
    chk("read answered", {31'h0, ok}, 32'h1);
    chk("read data", {24'h0, d}, {24'h0, exp});
  endtask : rdchk

  function automatic cgcr_pkg::cgcr_pcm_cfg_type pcm_exp(input logic [7:0] v);
    pcm_exp = '{slot_offset: v[2:0], double_clock: v[5], tx_falling: v[4],
      rx_rising: v[3], linear: v[6], mulaw: v[7]};
  endfunction : pcm_exp

  task automatic wait_change(input bit b, output int k);
    logic v;
    v = b ? O_CHOP_B : O_CHOP_A;
    k = 0;
    while ((b ? O_CHOP_B : O_CHOP_A) === v && k < 1200)
    begin
      @(posedge I_MCLK);
      #1;
      k++;
    end
  endtask : wait_change

  task automatic t_defaults;
    rdchk(7'h28, 8'h00);
    rdchk(7'h24, 8'h02);
    rdchk(7'h25, 8'h00);
    rdchk(7'h26, 8'h00);
    rdchk(7'h27, 8'h00);
    rdchk(7'h3f, 8'h00);
    chk("chop a", {31'h0, O_CHOP_A}, 32'h1);
    chk("chop b", {31'h0, O_CHOP_B}, 32'h1);
    chk("mclk code", {28'h0, O_MCLK_CODE}, 32'h2);
    chk("chan enable", {24'h0, O_CHAN_CMD_ENABLE}, 32'h0);
  endtask : t_defaults

  task automatic t_clock;
    logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'hd, 4'h4, 4'hc, 4'h6};
    foreach (codes[i])
    begin
      host.wr(8'ha4, {4'h0, codes[i]});
      chk("mclk code", {28'h0, O_MCLK_CODE}, {28'h0, codes[i]});
      chk("unresolved", {31'h0, O_CODE_UNRESOLVED}, {31'h0, codes[i] == 4'h6});
      rdchk(7'h24, {4'h0, codes[i]});
    end
    host.wr(8'ha4, 8'hf1);
    rdchk(7'h24, 8'h01);
  endtask : t_clock

  task automatic t_mask_pcm;
    logic [7:0] pv [8] = '{8'h07, 8'h08, 8'h10, 8'h18, 8'h25, 8'h40, 8'h80, 8'hff};
    host.wr(8'ha5, 8'ha5);
    chk("chan enable", {24'h0, O_CHAN_CMD_ENABLE}, 32'ha5);
    host.wr(8'ha5, 8'h5a);
    rdchk(7'h25, 8'h5a);
    foreach (pv[i])
    begin
      host.wr(8'ha6, pv[i]);
      chk("pcm cfg", {23'h0, O_PCM_CFG}, {23'h0, pcm_exp(pv[i])});
      rdchk(7'h26, pv[i]);
    end
  endtask : t_mask_pcm

  // serial mode: clock from the rate pin, parallel-only writes dropped
  task automatic t_serial;
    I_PARALLEL_MODE = 1'b0;
    repeat (4) @(posedge I_MCLK);
    #1;
    chk("mclk serial", {28'h0, O_MCLK_CODE}, 32'h2);
    chk("pcm serial", {23'h0, O_PCM_CFG}, {23'h0, pcm_exp(8'hc0)});
    I_DOUBLE_RATE = 1'b1;
    host.wr(8'ha4, 8'h05);
    host.wr(8'ha5, 8'hff);
    repeat (3) @(posedge I_MCLK);
    #1;
    chk("mclk double", {28'h0, O_MCLK_CODE}, 32'h1);
    I_DOUBLE_RATE = 1'b0;
    I_PARALLEL_MODE = 1'b1;
    repeat (4) @(posedge I_MCLK);
    rdchk(7'h24, 8'h01);
    rdchk(7'h25, 8'h5a);
  endtask : t_serial

  task automatic t_chopper;
    logic [3:0] ac [3] = '{4'h1, 4'hd, 4'he};
    int         bx [3] = '{cgcr_pkg::CHOP_B_F1_CYC, cgcr_pkg::CHOP_B_F2_CYC,
                          cgcr_pkg::CHOP_B_F3_CYC};
    int         n;
    foreach (bx[i])
    begin
      host.wr(8'ha7, {2'b00, 2'(i + 1), 4'h0});
      wait_change(1'b1, n);
      wait_change(1'b1, n);
      chk("chop b half", n, bx[i]);
    end
    foreach (ac[i])
    begin
      host.wr(8'ha7, {4'h0, ac[i]});
      chk("unresolved", {31'h0, O_CODE_UNRESOLVED}, {31'h0, ac[i] > 4'hd});
      wait_change(1'b0, n);
      wait_change(1'b0, n);
      chk("chop a half", n, 10 * ac[i]);
    end
    host.wr(8'ha7, 8'h00);
    wait_change(1'b0, n);
    chk("chop a steady", {31'h0, O_CHOP_A}, 32'h1);
    wait_change(1'b0, n);
    chk("chop a no toggle", n, 1200);
  endtask : t_chopper

  // short glitch must not pass the debounce
  task automatic t_sense;
    I_SENSE_A = 8'h5a;
    repeat (30) @(posedge I_MCLK);
    rdchk(7'h28, 8'h5a);
    I_SENSE_A = 8'ha5;
    repeat (3) @(posedge I_MCLK);
    // read while the glitch is still on the pin; a missing filter shows a5 here
    rdchk(7'h28, 8'h5a);
    I_SENSE_A = 8'h5a;
    repeat (30) @(posedge I_MCLK);
    rdchk(7'h28, 8'h5a);
  endtask : t_sense

  task automatic t_resets;
    int base;
    host.wr(8'ha5, 8'h3c);
    host.wr(8'ha4, 8'h05);
    base = pulses;
    host.global_cmd(8'ha2);
    host.global_cmd(8'ha0);
    repeat (2) @(posedge I_MCLK);
    chk("local reset pulses", pulses, base + 1);
    rdchk(7'h25, 8'h3c);
    rdchk(7'h24, 8'h05);
    host.global_cmd(8'ha3);
    t_defaults();
  endtask : t_resets

  // main sequence
  initial
  begin
    I_PARALLEL_MODE = 1'b1;
    I_DOUBLE_RATE   = 1'b0;
    I_SENSE_A       = 8'h00;
    repeat (6) @(posedge I_MCLK);
    #1;
    I_RST = 1'b0;
    repeat (3) @(posedge I_MCLK);
    t_defaults();
    t_clock();
    t_mask_pcm();
    t_serial();
    t_chopper();
    t_sense();
    t_resets();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
